/* hw/adc_serial_command_port.sv */
`timescale 1ns/1ns
// serial command port of the converter: link on serial clock,
// decode and configuration on the system clock
module adc_serial_command_port
  import adc_cmd_pkg::*;
(
  input  wire logic        clk_sys_i,
  input  wire logic        reset_i,
  // link pins
  input  wire logic        serial_clock_i,
  input  wire logic        chip_select_n_i,
  input  wire logic        serial_command_in_i,
  output logic             serial_result_out_o,
  output logic             serial_result_out_oe_o,
  output logic             conversion_done_strobe_o,
  // converter core side
  output logic             conv_start_o,
  output logic [2:0]       conv_pos_channel_o,
  output logic [2:0]       conv_neg_channel_o,
  output logic             conv_neg_is_ground_o,
  output logic             conv_differential_o,
  output logic [2:0]       conv_range_o,
  output logic [2:0]       mode_o,
  input  wire logic [13:0] result_i,
  input  wire logic        result_over_i,
  input  wire logic        result_under_i,
  input  wire logic        result_valid_i,
  output logic             result_ready_o
);
  // system domain state
  typedef struct packed {
    logic        rx_sync1;    // byte toggle, first stage
    logic        rx_sync2;
    logic        rx_seen;
    logic        ack_sync1;   // readout ack, first stage
    logic        ack_sync2;
    logic        ack_seen;
    mode_t       mode;
    logic        cfg_pending; // config read in flight
    logic        conv_busy;   // core converting
    logic        conv_start;
    logic [2:0]  pos_chan;
    logic [2:0]  neg_chan;
    logic        neg_ground;
    logic        diff;
    logic [2:0]  range;
    logic [13:0] tx_word;     // held while handed over
    logic        tx_toggle;
    logic        tx_wait;     // word handed, not yet taken
    logic        strobe;
    logic        link_busy;
  } sys_t;

  // receive framing, cleared by chip select
  typedef struct packed {
    logic       receiving;
    logic [2:0] count;
    logic [5:0] shreg;
  } rx_frame_t;

  // receive side crossing state
  typedef struct packed {
    logic [7:0] rx_byte;      // stable until next byte
    logic       rx_toggle;
    logic [2:0] mode_sync1;
    logic [2:0] mode_sync2;
    logic       busy_sync1;
    logic       busy_sync2;
  } rx_cross_t;

  // falling-edge transmit state
  typedef struct packed {
    logic        tx_sync1;
    logic        tx_sync2;
    logic        tx_seen;
    logic        ack_toggle;
    logic [13:0] shreg;       // bits not yet shown
    logic [3:0]  remain;
    logic        dout;
  } tx_t;

  sys_t      sys;       // system state
  sys_t      next_sys;
  rx_frame_t rx;        // link framing
  rx_frame_t next_rx;
  rx_cross_t rxc;       // link crossing
  rx_cross_t next_rxc;
  tx_t       tx;        // link output
  tx_t       next_tx;

  logic [13:0]         clamped;     // result after range clamp
  logic                buf_valid;   // buffer has a word
  logic [13:0]         buf_data;
  logic                cfg_wr_en;   // config write strobe
  logic                cfg_clear;   // mode reset clears all
  logic [CFG_BITS-1:0] cfg_rd;      // config of addressed channel
  logic                rx_event;    // new byte arrived
  logic                ack_event;   // readout began
  logic [7:0]          cmd;         // received byte view
  logic                start_ok;    // link may take a start bit
  logic                byte_done;   // eighth bit this edge
  logic [7:0]          byte_full;   // assembled byte

  // past-range inputs pin to the end code, never wrap
  // over wins when both flags are set
  always_comb begin
    if (result_over_i) begin
      clamped = CODE_FULL;
    end else if (result_under_i) begin
      clamped = CODE_ZERO;
    end else begin
      clamped = result_i;
    end
  end

  // results wait here while the link is busy or stalled
  two_entry_buffer #(
    .WIDTH (RESULT_BITS),
    .DEPTH (2)
  ) result_buf (
    .clk_sys_i   (clk_sys_i),
    .reset_i     (reset_i),
    .in_valid_i  (result_valid_i),
    .in_ready_o  (result_ready_o),
    .in_data_i   (clamped),
    .out_valid_o (buf_valid),
    .out_ready_i (!sys.tx_wait),
    .out_data_o  (buf_data)
  );

  // read address comes from the held byte, stable after the event
  cfg_memory cfg_store (
    .clk_sys_i (clk_sys_i),
    .reset_i   (reset_i),
    .clear_i   (cfg_clear),
    .wr_en_i   (cfg_wr_en),
    .wr_addr_i (cmd[6:4]),
    .wr_data_i (cmd[CFG_BITS-1:0]),
    .rd_addr_i (cmd[6:4]),
    .rd_data_o (cfg_rd)
  );

  // byte held steady before its toggle
  assign cmd       = rxc.rx_byte;
  assign rx_event  = sys.rx_sync2 != sys.rx_seen;
  assign ack_event = sys.ack_sync2 != sys.ack_seen;

  // system domain: decode, configuration, handover
  always_comb begin
    next_sys = sys;
    cfg_wr_en = 1'b0;
    cfg_clear = 1'b0;
    next_sys.rx_sync1  = rxc.rx_toggle;
    next_sys.rx_sync2  = sys.rx_sync1;
    next_sys.ack_sync1 = tx.ack_toggle;
    next_sys.ack_sync2 = sys.ack_sync1;
    next_sys.conv_start = 1'b0;
    if (rx_event) begin
      next_sys.rx_seen = sys.rx_sync2;
      if (cmd[CMD_START]) begin
        if (cmd[3:0] == NIB_CONV) begin
          // starts only in a conversion mode and when idle
          if (!sys.conv_busy && !sys.cfg_pending &&
              (sys.mode == MODE_EXT_CLK || sys.mode == MODE_EXT_ACQ ||
               sys.mode == MODE_INT_CLK)) begin
            next_sys.cfg_pending = 1'b1;
          end
        end else if (cmd[3:0] == NIB_MODE) begin
          case (cmd[6:4])
            MODE_RESET: begin
              cfg_clear = 1'b1;
              next_sys.mode = MODE_EXT_CLK;
            end
            MODE_EXT_CLK, MODE_EXT_ACQ, MODE_INT_CLK,
            MODE_PART_PD, MODE_FULL_PD: begin
              next_sys.mode = mode_t'(cmd[6:4]);
            end
            default: begin
              // unused codes leave the mode alone
            end
          endcase
        end else if (!cfg_refused(cmd)) begin
          // pair settings live at the even channel
          cfg_wr_en = 1'b1;
        end
      end
    end
    // config read back one cycle later: issue the conversion
    // read config rides with the request
    if (sys.cfg_pending) begin
      next_sys.cfg_pending = 1'b0;
      next_sys.conv_start  = 1'b1;
      next_sys.conv_busy   = 1'b1;
      next_sys.pos_chan    = cmd[6:4];
      next_sys.diff        = cfg_rd[CMD_DIFF];
      next_sys.range       = cfg_rd[2:0];
      if (cfg_rd[CMD_DIFF]) begin
        next_sys.neg_ground = 1'b0;
        next_sys.neg_chan   = {cmd[6:5], 1'b1};
      end else begin
        next_sys.neg_ground = 1'b1;
        next_sys.neg_chan   = cmd[6:4];
      end
    end
    // core result taken into the buffer ends the conversion
    if (result_valid_i && result_ready_o) begin
      next_sys.conv_busy = 1'b0;
    end
    // hand the next word to the link, held until acked
    if (buf_valid && !sys.tx_wait) begin
      next_sys.tx_word   = buf_data;
      next_sys.tx_toggle = !sys.tx_toggle;
      next_sys.tx_wait   = 1'b1;
    end else if (ack_event) begin
      next_sys.tx_wait = 1'b0;
    end
    if (ack_event) begin
      next_sys.ack_seen = sys.ack_sync2;
    end
    // strobe only where the master waits for it
    next_sys.strobe = next_sys.tx_wait &&
                      (next_sys.mode == MODE_EXT_ACQ ||
                       next_sys.mode == MODE_INT_CLK);
    // anything in flight blocks a start bit
    next_sys.link_busy = next_sys.conv_busy || next_sys.cfg_pending ||
                         next_sys.tx_wait || buf_valid;
  end

  // register the system copy
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      sys <= '0;
      sys.mode <= MODE_EXT_CLK;
    end else begin
      sys <= next_sys;
    end
  end

  // start bit waits for idle, or for the tail of a readout;
  // the master keeps the line low meanwhile, so the sync lag is safe
  assign start_ok = !rxc.busy_sync2 &&
                    (tx.remain <= readout_left(rxc.mode_sync2));

  // link rising edge: collect one command byte
  always_comb begin
    next_rx = rx;
    byte_done = 1'b0;
    byte_full = {1'b1, rx.shreg, serial_command_in_i};
    if (!rx.receiving) begin
      if (serial_command_in_i && start_ok) begin
        next_rx.receiving = 1'b1;
        next_rx.count     = 3'h0;
      end
    end else begin
      next_rx.shreg = {rx.shreg[4:0], serial_command_in_i};
      next_rx.count = rx.count + 3'h1;
      // start bit counted apart: 7 data edges
      if (rx.count == 3'h6) begin
        byte_done = 1'b1;
        next_rx.receiving = 1'b0;
      end
    end
  end

  // chip select high holds framing cleared, edges ignored
  always_ff @(posedge serial_clock_i or posedge chip_select_n_i) begin
    if (chip_select_n_i) begin
      rx <= '0;
    end else begin
      rx <= next_rx;
    end
  end

  // link rising edge: publish bytes, sync mode and busy
  always_comb begin
    next_rxc = rxc;
    // slow levels; a torn mode word lasts one edge
    // and only shifts the start window a little
    next_rxc.mode_sync1 = sys.mode;
    next_rxc.mode_sync2 = rxc.mode_sync1;
    next_rxc.busy_sync1 = sys.link_busy;
    next_rxc.busy_sync2 = rxc.busy_sync1;
    if (byte_done) begin
      next_rxc.rx_byte   = byte_full;
      next_rxc.rx_toggle = !rxc.rx_toggle;
    end
  end

  // toggles must survive chip select, so only reset clears them
  always_ff @(posedge serial_clock_i or posedge reset_i) begin
    if (reset_i) begin
      rxc <= '0;
    end else begin
      rxc <= next_rxc;
    end
  end

  // link falling edge: shift the result out msb first
  always_comb begin
    next_tx = tx;
    // toggle crosses in two falling-edge stages
    next_tx.tx_sync1 = sys.tx_toggle;
    next_tx.tx_sync2 = tx.tx_sync1;
    if (!chip_select_n_i) begin
      if (tx.remain != 4'h0) begin
        next_tx.dout   = tx.shreg[RESULT_BITS-1];
        next_tx.shreg  = {tx.shreg[RESULT_BITS-2:0], 1'b0};
        next_tx.remain = tx.remain - 4'h1;
      end else if (tx.tx_sync2 != tx.tx_seen) begin
        // word held stable by the system side until acked
        next_tx.dout       = sys.tx_word[RESULT_BITS-1];
        next_tx.shreg      = {sys.tx_word[RESULT_BITS-2:0], 1'b0};
        next_tx.remain     = LOAD_LEFT;
        next_tx.tx_seen    = tx.tx_sync2;
        next_tx.ack_toggle = !tx.ack_toggle;
      end else begin
        next_tx.dout = 1'b0;
      end
    end
  end

  // register the transmit copy
  always_ff @(negedge serial_clock_i or posedge reset_i) begin
    if (reset_i) begin
      tx <= '0;
    end else begin
      tx <= next_tx;
    end
  end

  // output drive follows chip select directly
  assign serial_result_out_o      = tx.dout;
  assign serial_result_out_oe_o   = !chip_select_n_i;
  assign conversion_done_strobe_o = sys.strobe;
  assign conv_start_o             = sys.conv_start;
  assign conv_pos_channel_o       = sys.pos_chan;
  assign conv_neg_channel_o       = sys.neg_chan;
  assign conv_neg_is_ground_o     = sys.neg_ground;
  assign conv_differential_o      = sys.diff;
  assign conv_range_o             = sys.range;
  assign mode_o                   = sys.mode;
endmodule

/* common/adc_cmd_pkg.sv */
// Function
// - one command byte, start bit, three formats
// - single-ended code picks channel against ground
// - differential even codes pick pairs, odd reserved
// - each channel keeps its own range
// - each pair keeps its own range
// - over-range input gives full-scale code
// - mode byte selects one of six modes
// - sample on rising, change output on falling
// - chip select high: ignore link, release output
// - done strobe always driven
// - strobe high when result ready (modes 1,2)
// - strobe low in external clock mode
// - first 1 while idle starts a byte
// - start bit allowed near end of readout
// - result shifted msb first from bit 13
package adc_cmd_pkg;
  localparam int unsigned RESULT_BITS  = 14;
  localparam int unsigned CHAN_COUNT   = 8;
  localparam int unsigned CFG_BITS     = 4;  // {diff, range}
  localparam int unsigned CMD_START    = 7;
  localparam int unsigned CMD_CHAN_LO  = 4;
  localparam int unsigned CMD_DIFF     = 3;
  localparam logic [3:0] NIB_CONV      = 4'h0;
  localparam logic [3:0] NIB_MODE      = 4'h8;
  localparam logic [3:0] CFG_RESET     = 4'h7;  // single-ended, widest range
  localparam logic [3:0] LEFT_EXT_CLK  = 4'h1;  // bits still unshown
  localparam logic [3:0] LEFT_EXT_ACQ  = 4'h5;
  localparam logic [3:0] LEFT_INT_CLK  = 4'h2;
  localparam logic [3:0] LOAD_LEFT     = 4'hd;  // bits after bit 13
  localparam logic [13:0] CODE_FULL    = 14'h3fff;
  localparam logic [13:0] CODE_ZERO    = 14'h0000;

  typedef enum logic [2:0] {
    MODE_EXT_CLK  = 3'b000,
    MODE_EXT_ACQ  = 3'b001,
    MODE_INT_CLK  = 3'b010,
    MODE_RESET    = 3'b100,
    MODE_PART_PD  = 3'b110,
    MODE_FULL_PD  = 3'b111
  } mode_t;

  // readout bits that may remain when a new start bit is taken
  function automatic logic [3:0] readout_left(input logic [2:0] m);
    if (m == MODE_EXT_ACQ) return LEFT_EXT_ACQ;
    else if (m == MODE_INT_CLK) return LEFT_INT_CLK;
    else return LEFT_EXT_CLK;
  endfunction

  // odd pair code or reserved differential range
  function automatic logic cfg_refused(input logic [7:0] b);
    logic [2:0] r;
    r = b[2:0];
    return b[CMD_DIFF] && (b[CMD_CHAN_LO] || r == 3'h2 || r == 3'h3
                           || r == 3'h5 || r == 3'h6);
  endfunction
endpackage

/* hw/cfg_memory.sv */
`timescale 1ns/1ns
// per-channel input configuration store, registered read
module cfg_memory
  import adc_cmd_pkg::*;
(
  input  wire logic                clk_sys_i,
  input  wire logic                reset_i,
  input  wire logic                clear_i,   // back to defaults
  input  wire logic                wr_en_i,
  input  wire logic [2:0]          wr_addr_i,
  input  wire logic [CFG_BITS-1:0] wr_data_i,
  input  wire logic [2:0]          rd_addr_i,
  output logic      [CFG_BITS-1:0] rd_data_o
);
  typedef struct packed {
    logic [CHAN_COUNT-1:0][CFG_BITS-1:0] entry;
    logic [CFG_BITS-1:0]                 rd_data;
  } mem_t;
  mem_t mem;       // all state
  mem_t next_mem;  // next state

  // clear beats a write in the same cycle
  always_comb begin
    next_mem = mem;
    if (clear_i) begin
      next_mem.entry = {CHAN_COUNT{CFG_RESET}};
    end else if (wr_en_i) begin
      next_mem.entry[wr_addr_i] = wr_data_i;
    end
    next_mem.rd_data = mem.entry[rd_addr_i];
  end

  // register the copy
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      mem <= {{CHAN_COUNT{CFG_RESET}}, CFG_RESET};
    end else begin
      mem <= next_mem;
    end
  end

  assign rd_data_o = mem.rd_data;
endmodule

/* hw/two_entry_buffer.sv */
`timescale 1ns/1ns
// small fifo with valid/ready on both sides
module two_entry_buffer #(
  parameter int unsigned WIDTH = 14,
  parameter int unsigned DEPTH = 2
) (
  input  wire logic             clk_sys_i,
  input  wire logic             reset_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int unsigned PW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] slot;
    logic [PW-1:0]               wr_ptr;
    logic [PW-1:0]               rd_ptr;
    logic [PW:0]                 count;
  } buf_t;
  buf_t st;       // all state
  buf_t next_st;  // next state
  logic push;     // word accepted
  logic pop;      // word delivered

  // handshakes straight from the fill count
  assign in_ready_o  = (st.count != DEPTH[PW:0]);
  assign out_valid_o = (st.count != '0);
  assign out_data_o  = st.slot[st.rd_ptr];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  // pointer wrap relies on depth being a power of two
  always_comb begin
    next_st = st;
    if (push) begin
      next_st.slot[st.wr_ptr] = in_data_i;
      next_st.wr_ptr = st.wr_ptr + 1'b1;
    end
    if (pop) begin
      next_st.rd_ptr = st.rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      next_st.count = st.count + 1'b1;
    end else if (pop && !push) begin
      next_st.count = st.count - 1'b1;
    end
  end

  // register the copy
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule

/* verification/adc_port_monitor.sv */
`timescale 1ns/1ns
// pin and core-side relations of the command port
module adc_port_monitor
  import adc_cmd_pkg::*;
(
  input  wire logic       clk_sys_i,
  input  wire logic       reset_i,
  input  wire logic       chip_select_n_i,
  input  wire logic       serial_result_out_oe_o,
  input  wire logic       conversion_done_strobe_o,
  input  wire logic       conv_start_o,
  input  wire logic [2:0] conv_pos_channel_o,
  input  wire logic [2:0] conv_neg_channel_o,
  input  wire logic       conv_neg_is_ground_o,
  input  wire logic       conv_differential_o,
  input  wire logic [2:0] conv_range_o,
  input  wire logic [2:0] mode_o
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (reset_i);

  // a request to the core, split by input kind
  sequence s_go;
    conv_start_o;
  endsequence
  sequence s_go_diff;
    conv_start_o && conv_differential_o;
  endsequence
  sequence s_go_single;
    conv_start_o && !conv_differential_o;
  endsequence
  // result announced to the master
  sequence s_strobe_up;
    $rose(conversion_done_strobe_o);
  endsequence

  oe_follows_cs_a: assert property (serial_result_out_oe_o == !chip_select_n_i)
    else $error("result enable differs from chip select");
  strobe_ext_low_a: assert property (mode_o == MODE_EXT_CLK
    |-> !conversion_done_strobe_o)
    else $error("strobe high in external clock mode");
  strobe_rise_mode_a: assert property (s_strobe_up |-> mode_o inside {3'h1, 3'h2})
    else $error("strobe rose outside strobe modes");
  single_ground_a: assert property (s_go_single |-> conv_neg_is_ground_o)
    else $error("single-ended request without ground side");
  diff_pair_a: assert property (s_go_diff |-> !conv_pos_channel_o[0]
    && conv_neg_channel_o == (conv_pos_channel_o | 3'h1) && !conv_neg_is_ground_o)
    else $error("differential request with wrong pair");
  diff_range_a: assert property (s_go_diff |-> conv_range_o inside {3'h1, 3'h4, 3'h7})
    else $error("differential request with reserved range");
  range_set_a: assert property (s_go |-> conv_range_o != 3'h0)
    else $error("request with no range set");
  no_start_pd_a: assert property (s_go |-> !(mode_o inside {3'h6, 3'h7}))
    else $error("conversion started while powered down");
  start_single_a: assert property (s_go |=> !conv_start_o [*8])
    else $error("second start too close to the first");
  mode_legal_a: assert property (mode_o inside {3'h0, 3'h1, 3'h2, 3'h6, 3'h7})
    else $error("mode output holds an unused code");
  cover property (s_strobe_up);
endmodule

bind adc_serial_command_port adc_port_monitor i_monitor (
  .clk_sys_i                (clk_sys_i),
  .reset_i                  (reset_i),
  .chip_select_n_i          (chip_select_n_i),
  .serial_result_out_oe_o   (serial_result_out_oe_o),
  .conversion_done_strobe_o (conversion_done_strobe_o),
  .conv_start_o             (conv_start_o),
  .conv_pos_channel_o       (conv_pos_channel_o),
  .conv_neg_channel_o       (conv_neg_channel_o),
  .conv_neg_is_ground_o     (conv_neg_is_ground_o),
  .conv_differential_o      (conv_differential_o),
  .conv_range_o             (conv_range_o),
  .mode_o                   (mode_o)
);

/* verification/serial_master.sv */
`timescale 1ns/1ns
// link master: clock idle low, runs only inside transfers after one start-up pulse, 48 ns period
module serial_master (
  output logic      sclk_o,
  output logic      cs_n_o,
  output logic      din_o,
  input  wire logic sdo_i,
  input  wire logic sdo_oe_i
);
  logic last_bit;  // last bit seen; a released line is taken to show its inverse

  initial begin
    sclk_o   = 1'b0;
    cs_n_o   = 1'b1;
    din_o    = 1'b0;
    last_bit = 1'b0;
    // one pulse while deselected and in reset clears link flops
    #1 sclk_o = 1'b1;
    #24 sclk_o = 1'b0;
  end

  // odd offset keeps link edges off the system clock edges
  task automatic begin_frame();
    #1;
    cs_n_o = 1'b0;
    #30;
  endtask

  task automatic end_frame();
    #30;
    cs_n_o = 1'b1;
    #100;
  endtask

  // one byte msb first, data set while low, result sampled at the rise
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    logic line;
    for (int i = 7; i >= 0; i--) begin
      din_o = tx[i];
      // 48 ns is past the analog rate limit; the logic has none
      #24;
      sclk_o = 1'b1;
      line = (sdo_oe_i === 1'b1) ? sdo_i : ~last_bit;  // no pull on the line
      last_bit = line;
      rx[i] = line;
      #24;
      sclk_o = 1'b0;
    end
    din_o = 1'b0;
  endtask
endmodule

/* verification/testbench.sv */
`timescale 1ns/1ns
module testbench
  import adc_cmd_pkg::*;
;
  typedef struct {
    logic [7:0] cfg, start;
    logic [2:0] pos, neg, rng;
    logic gnd, dif, over, under;
    logic [13:0] res, word;
  } row_t;
  // config byte (0 = none), start byte, expected request, core answer, readout
  row_t rows [8] = '{
    '{8'h93, 8'h90, 3'h1, 3'h0, 3'h3, 1'b1, 1'b0, 1'b0, 1'b0, 14'h2a5c, 14'h2a5c},
    '{8'hf1, 8'hf0, 3'h7, 3'h0, 3'h1, 1'b1, 1'b0, 1'b1, 1'b0, 14'h3001, 14'h3fff},
    '{8'hac, 8'ha0, 3'h2, 3'h3, 3'h4, 1'b0, 1'b1, 1'b0, 1'b1, 14'h2fff, 14'h0000},
    '{8'hef, 8'he0, 3'h6, 3'h7, 3'h7, 1'b0, 1'b1, 1'b1, 1'b1, 14'h2001, 14'h3fff},
    '{8'h89, 8'h80, 3'h0, 3'h1, 3'h1, 1'b0, 1'b1, 1'b0, 1'b0, 14'h3ffe, 14'h3ffe},
    '{8'hbc, 8'hb0, 3'h3, 3'h0, 3'h7, 1'b1, 1'b0, 1'b0, 1'b0, 14'h2123, 14'h2123},
    '{8'hca, 8'hc0, 3'h4, 3'h0, 3'h7, 1'b1, 1'b0, 1'b0, 1'b0, 14'h2456, 14'h2456},
    '{8'h00, 8'h90, 3'h1, 3'h0, 3'h3, 1'b1, 1'b0, 1'b0, 1'b0, 14'h2789, 14'h2789}};
  row_t        clr_row = '{8'h00, 8'h90, 3'h1, 3'h0, 3'h7, 1'b1, 1'b0, 1'b0, 1'b0,
                           14'h2aaa, 14'h2aaa};
  logic [2:0]  mcode [7] = '{3'h1, 3'h2, 3'h3, 3'h6, 3'h5, 3'h7, 3'h4};
  logic [2:0]  mexp [7]  = '{3'h1, 3'h2, 3'h2, 3'h6, 3'h6, 3'h7, 3'h0};
  logic [13:0] bw [3]    = '{14'h2111, 14'h2222, 14'h2333};
  logic        clk_sys_i, reset_i, sclk, cs_n, din, sdo, sdo_oe, strobe, conv_start;
  logic [2:0]  pos, neg, rng, mode, cap_pos, cap_neg, cap_rng;
  logic        gnd, dif, cap_gnd, cap_dif, res_over, res_under, res_ready;
  logic [13:0] res_data;
  logic        core_v, push_v;  // core answer, buffer test push
  wire         res_valid = core_v | push_v;
  int          n_errors = 0, checked = 0, n_starts = 0;

  adc_serial_command_port i_dut (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
    .serial_clock_i(sclk), .chip_select_n_i(cs_n), .serial_command_in_i(din),
    .serial_result_out_o(sdo), .serial_result_out_oe_o(sdo_oe),
    .conversion_done_strobe_o(strobe), .conv_start_o(conv_start),
    .conv_pos_channel_o(pos), .conv_neg_channel_o(neg), .conv_neg_is_ground_o(gnd),
    .conv_differential_o(dif), .conv_range_o(rng), .mode_o(mode), .result_i(res_data),
    .result_over_i(res_over), .result_under_i(res_under), .result_valid_i(res_valid),
    .result_ready_o(res_ready));
  serial_master i_master (.sclk_o(sclk), .cs_n_o(cs_n), .din_o(din), .sdo_i(sdo),
    .sdo_oe_i(sdo_oe));

  initial begin
    clk_sys_i = 1'b0;
    forever #2 clk_sys_i = ~clk_sys_i;
  end

  // core stand-in: answers each request on the next cycle, keeps the request
  always @(posedge clk_sys_i) begin
    core_v <= (conv_start === 1'b1);
    if (conv_start === 1'b1) begin
      n_starts <= n_starts + 1;
      {cap_pos, cap_neg, cap_rng, cap_gnd, cap_dif} <= {pos, neg, rng, gnd, dif};
    end
  end

  task automatic cmp_bit(input string what, input logic e, input logic g);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %b seen %b", what, e, g);
    end
  endtask
  task automatic cmp_field(input string what, input logic [2:0] e, input logic [2:0] g);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic cmp_word(input string what, input logic [13:0] e, input logic [13:0] g);
    checked++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask

  // four bytes of zeros; the word starts at the first 1 (bit 13 set)
  task automatic read_bits(output logic [13:0] w);
    logic [7:0]  rx;
    logic [31:0] s;
    for (int i = 0; i < 4; i++) begin
      i_master.xfer(8'h00, rx);
      s = {s[23:0], rx};
    end
    w = 14'h0000;
    for (int i = 31; i >= 13; i--) begin
      if (s[i] === 1'b1 && w === 14'h0000) w = s[i -: 14];
    end
  endtask
  task automatic read_frame(output logic [13:0] w);
    @(posedge clk_sys_i);
    i_master.begin_frame();
    read_bits(w);
    i_master.end_frame();
  endtask
  task automatic send_cmd(input logic [7:0] b);
    logic [7:0] rx;
    @(posedge clk_sys_i);
    i_master.begin_frame();
    i_master.xfer(b, rx);
    i_master.end_frame();
    repeat (20) @(posedge clk_sys_i);
  endtask

  // configure, start, read out in one frame (external clock mode)
  task automatic run_row(input row_t r);
    logic [7:0]  rx;
    logic [13:0] w;
    @(posedge clk_sys_i);
    {res_data, res_over, res_under} <= {r.res, r.over, r.under};
    i_master.begin_frame();
    if (r.cfg !== 8'h00) i_master.xfer(r.cfg, rx);
    i_master.xfer(r.start, rx);
    read_bits(w);
    i_master.end_frame();
    cmp_field("positive input", r.pos, cap_pos);
    if (r.dif) cmp_field("negative input", r.neg, cap_neg);
    cmp_bit("ground side", r.gnd, cap_gnd);
    cmp_bit("differential", r.dif, cap_dif);
    cmp_field("range", r.rng, cap_rng);
    cmp_word("readout", r.word, w);
  endtask

  // one word into the buffer, valid held until it is taken
  task automatic push_word(input logic [13:0] w);
    int t;
    @(posedge clk_sys_i);
    res_data <= w;
    push_v <= 1'b1;
    t = 0;
    @(negedge clk_sys_i);
    while (res_ready !== 1'b1 && t < 20) begin
      @(negedge clk_sys_i);
      t++;
    end
    cmp_bit("word taken", 1'b1, res_ready);
    @(posedge clk_sys_i);
    push_v <= 1'b0;
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // watchdog: the whole sequence needs well under 60 us
  initial begin
    #200000;
    n_errors++;
    tally_and_finish();
  end

  initial begin
    logic [7:0]  rx;
    logic [13:0] w;
    int          s0;
    {reset_i, core_v, push_v, res_over, res_under, res_data} = {1'b1, 18'h0_0000};
    repeat (16) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    @(negedge clk_sys_i);
    cmp_field("mode after reset", 3'h0, mode);
    cmp_bit("strobe after reset", 1'b0, strobe);
    $display("test reset done");
    foreach (rows[i]) run_row(rows[i]);
    $display("test table done");
    // a byte clocked while deselected must leave channel 1 alone
    @(posedge clk_sys_i);
    #1;
    i_master.xfer(8'h97, rx);
    run_row(rows[7]);
    $display("test deselect done");
    for (int k = 0; k < 7; k++) begin
      send_cmd({1'b1, mcode[k], 4'h8});
      cmp_field("mode", mexp[k], mode);
      if (mexp[k] >= 3'h6) begin
        s0 = n_starts;
        send_cmd(8'h90);
        cmp_bit("start refused", 1'b1, n_starts == s0);
      end
    end
    run_row(clr_row);
    $display("test modes done");
    for (int m = 1; m <= 2; m++) begin
      send_cmd({1'b1, 3'(m), 4'h8});
      @(posedge clk_sys_i);
      res_data <= 14'h2c3a;
      send_cmd(8'h90);
      for (int t = 0; t < 300 && strobe !== 1'b1; t++) @(negedge clk_sys_i);
      cmp_bit("strobe up", 1'b1, strobe);
      read_frame(w);
      cmp_word("strobe mode readout", 14'h2c3a, w);
      repeat (20) @(negedge clk_sys_i);
      cmp_bit("strobe after read", 1'b0, strobe);
    end
    $display("test strobe done");
    foreach (bw[k]) push_word(bw[k]);
    @(negedge clk_sys_i);
    cmp_bit("buffer full", 1'b0, res_ready);
    read_frame(w);
    cmp_word("oldest word", bw[0], w);
    $display("test buffer done");
    tally_and_finish();
  end
endmodule
